// file: lockdown_pkg.sv
// Package for the cache segment lockdown block.
// Shared by the lockdown controller and its segment allocator.
package lockdown_pkg;
    localparam int NUM_SEGMENTS = 4;
    localparam int SEG_W = 2;
    localparam int MAX_LOCKED = 3;
    localparam int LINE_WORDS = 8;
    localparam int LINE_BYTES = 32;
    localparam int WORD_W = 3;
    // Lockdown control register layout
    localparam int LOAD_BIT = 31;
    localparam int SEG_LSB = 0;
    localparam logic [31:0] LOCKDOWN_RESET = 32'h0000_0000;
    // Coprocessor register numbers
    localparam logic [3:0] CREG_LOCKDOWN = 4'h9;
    localparam logic [3:0] CREG_CACHEOP = 4'h7;
    localparam logic [3:0] CM_PRELOAD = 4'hd;
    localparam logic [2:0] OP2_DATA = 3'h0;
    localparam logic [2:0] OP2_INSTR = 3'h1;

    typedef struct packed {
        logic valid;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
        logic [31:0] data;
    } cop_write_t;

    typedef struct packed {
        logic loadMode;
        logic [1:0] segment;
    } lock_ctrl_t;

    typedef enum logic [1:0] {
        FILL_IDLE = 2'b00,
        FILL_BUSY = 2'b01
    } fill_state_t;
endpackage

// file: segment_alloc.sv
// Victim segment selector for one cache.
// Keeps its own round robin counter as the replacement hint, updated on the same clock as a fill start outside load mode.
`timescale 1ns/1ps
`default_nettype none
module segment_alloc
    import lockdown_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire lock_ctrl_t ctrl,
    input wire logic fillStart,
    output logic [1:0] victim
);
    logic [1:0] rr;
    logic [1:0] next_rr;
    logic [1:0] next_victim;

    // Round robin over unlocked segments only; segment field marks the lock base
    always_comb
    begin
        next_rr = rr;
        next_victim = victim;
        if (fillStart)
        begin
            if (ctrl.loadMode)
                next_victim = ctrl.segment;
            else
            begin
                // Segments below the lock base are never chosen
                next_victim = (rr < ctrl.segment) ? ctrl.segment : rr;
                next_rr = (next_victim == 2'h3) ? ctrl.segment : 2'(next_victim + 2'h1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rr <= 2'h0;
            victim <= 2'h0;
        end
        else
        begin
            rr <= next_rr;
            victim <= next_victim;
        end
    end

    // A normal fill must land at or above the lock base
    property p_no_locked_victim;
        @(posedge clock) disable iff (!rst_n)
        $past(fillStart) && !$past(ctrl.loadMode) |-> victim >= $past(ctrl.segment);
    endproperty
    a_no_locked_victim: assert property (p_no_locked_victim) else $error("victim taken from a locked segment");
endmodule
`default_nettype wire

// file: cache_segment_lockdown.sv
// Lockdown controller for a four-segment instruction cache and data cache.
// Assumes the core presents coprocessor writes and read-miss fill requests on the core clock,
// and that the cache signals each written fill word with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module cache_segment_lockdown
    import lockdown_pkg::*;
#(
    parameter int SEGMENTS = NUM_SEGMENTS,
    parameter int FILL_WORDS = LINE_WORDS
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire cop_write_t copWrite,
    input wire logic copReadReq,
    input wire logic [2:0] copReadOp2,
    input wire logic dataMiss,
    input wire logic fillWordDone,
    output logic [31:0] copReadData,
    output lock_ctrl_t dataCtrl,
    output lock_ctrl_t instrCtrl,
    output logic fillReq,
    output logic fillIsInstr,
    output logic [1:0] fillSegment,
    output logic fillBusy,
    output logic [31:0] preloadAddr
);
    // Elaboration check: the sequencer and allocators are sized for four segments of eight words
    if (SEGMENTS != NUM_SEGMENTS || FILL_WORDS != LINE_WORDS)
    begin : g_bad_params
        $error("only four segments of eight-word lines are supported");
    end

    fill_state_t state;
    fill_state_t next_state;
    lock_ctrl_t next_dataCtrl;
    lock_ctrl_t next_instrCtrl;
    logic [WORD_W-1:0] wordCount;
    logic [WORD_W-1:0] next_wordCount;
    logic next_fillReq;
    logic next_fillIsInstr;
    logic next_fillBusy;
    logic [31:0] next_preloadAddr;
    logic [31:0] next_copReadData;
    logic [1:0] dataVictim;
    logic [1:0] instrVictim;
    logic wrLock;
    logic wrPreload;
    logic startData;
    logic startInstr;

    // Decode a write aimed at a lockdown register, one per cache
    function automatic logic isLockWrite(input cop_write_t w, input logic [2:0] op2);
        return w.valid && w.crn == CREG_LOCKDOWN && w.op2 == op2;
    endfunction

    // Pack a control set into its register image
    function automatic logic [31:0] lockImage(input lock_ctrl_t c);
        logic [31:0] img;
        img = 32'h0000_0000;
        img[LOAD_BIT] = c.loadMode;
        img[SEG_LSB +: SEG_W] = c.segment;
        return img;
    endfunction

    assign wrLock = isLockWrite(copWrite, OP2_DATA) || isLockWrite(copWrite, OP2_INSTR);
    assign wrPreload = copWrite.valid && copWrite.crn == CREG_CACHEOP && copWrite.crm == CM_PRELOAD
        && copWrite.op2 == OP2_INSTR;
    // A new fill starts only when none is in flight; the single-fill limit is why software waits
    assign startData = dataMiss && state == FILL_IDLE;
    assign startInstr = wrPreload && state == FILL_IDLE && !dataMiss;

    // Lockdown registers; the data segment is clamped so one segment always stays free, the instruction segment is stored as written
    always_comb
    begin
        next_dataCtrl = dataCtrl;
        next_instrCtrl = instrCtrl;
        if (isLockWrite(copWrite, OP2_DATA))
        begin
            next_dataCtrl.loadMode = copWrite.data[LOAD_BIT];
            next_dataCtrl.segment = (copWrite.data[SEG_LSB +: SEG_W] > 2'(MAX_LOCKED)) ? 2'(MAX_LOCKED)
                : copWrite.data[SEG_LSB +: SEG_W];
        end
        if (isLockWrite(copWrite, OP2_INSTR))
        begin
            next_instrCtrl.loadMode = copWrite.data[LOAD_BIT];
            next_instrCtrl.segment = copWrite.data[SEG_LSB +: SEG_W];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dataCtrl <= '0;
            instrCtrl <= '0;
        end
        else
        begin
            dataCtrl <= next_dataCtrl;
            instrCtrl <= next_instrCtrl;
        end
    end

    // Line fill sequencer: one line of eight words into the victim segment
    always_comb
    begin
        next_state = state;
        next_wordCount = wordCount;
        next_fillReq = 1'b0;
        next_fillIsInstr = fillIsInstr;
        next_preloadAddr = preloadAddr;
        unique case (state)
            FILL_IDLE:
            begin
                next_wordCount = '0;
                if (startData || startInstr)
                begin
                    next_state = FILL_BUSY;
                    next_fillReq = 1'b1;
                    next_fillIsInstr = startInstr;
                    if (startInstr)
                        next_preloadAddr = {copWrite.data[31:5], 5'h00};
                end
            end
            FILL_BUSY:
            begin
                if (fillWordDone)
                begin
                    next_wordCount = 3'(wordCount + 3'h1);
                    if (wordCount == 3'(LINE_WORDS - 1))
                        next_state = FILL_IDLE;
                end
            end
        endcase
        // Busy flag kept in its own flop so the output comes straight from a register
        next_fillBusy = (next_state == FILL_BUSY);
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= FILL_IDLE;
            fillBusy <= 1'b0;
            wordCount <= '0;
            fillReq <= 1'b0;
            fillIsInstr <= 1'b0;
            preloadAddr <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            fillBusy <= next_fillBusy;
            wordCount <= next_wordCount;
            fillReq <= next_fillReq;
            fillIsInstr <= next_fillIsInstr;
            preloadAddr <= next_preloadAddr;
        end
    end

    // Per-cache victim choice, one segment of four per fill
    segment_alloc u_data_alloc (
        .clock(clock),
        .rst_n(rst_n),
        .ctrl(dataCtrl),
        .fillStart(startData),
        .victim(dataVictim)
    );
    segment_alloc u_instr_alloc (
        .clock(clock),
        .rst_n(rst_n),
        .ctrl(instrCtrl),
        .fillStart(startInstr),
        .victim(instrVictim)
    );
    assign fillSegment = fillIsInstr ? instrVictim : dataVictim;

    // Register read-back; answer one cycle after the request
    always_comb
    begin
        next_copReadData = copReadData;
        if (copReadReq)
            next_copReadData = (copReadOp2 == OP2_INSTR) ? lockImage(instrCtrl) : lockImage(dataCtrl);
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            copReadData <= LOCKDOWN_RESET;
        else
            copReadData <= next_copReadData;
    end

    // The eighth written word ends the fill on the next edge
    property p_fill_end;
        @(posedge clock) disable iff (!rst_n)
        fillBusy && fillWordDone && wordCount == 3'(LINE_WORDS - 1) |=> !fillBusy;
    endproperty
    a_fill_end: assert property (p_fill_end) else $error("fill did not end after eight words");
    // Before the eighth word the fill must stay busy
    property p_fill_hold;
        @(posedge clock) disable iff (!rst_n)
        fillBusy && !(fillWordDone && wordCount == 3'(LINE_WORDS - 1)) |=> fillBusy;
    endproperty
    a_fill_hold: assert property (p_fill_hold) else $error("fill ended before eight words");
    property p_seg_cap;
        @(posedge clock) disable iff (!rst_n)
        dataCtrl.segment <= 2'(MAX_LOCKED);
    endproperty
    a_seg_cap: assert property (p_seg_cap) else $error("data lock segment beyond limit");
    property p_read_img;
        @(posedge clock) disable iff (!rst_n)
        copReadReq && copReadOp2 == OP2_DATA |=> copReadData[LOAD_BIT] == $past(dataCtrl.loadMode)
        && copReadData[1:0] == $past(dataCtrl.segment) && copReadData[30:2] == 29'h0;
    endproperty
    a_read_img: assert property (p_read_img) else $error("data lockdown read image wrong");
    property p_data_seg;
        @(posedge clock) disable iff (!rst_n)
        startData && dataCtrl.loadMode |=> fillSegment == $past(dataCtrl.segment);
    endproperty
    a_data_seg: assert property (p_data_seg) else $error("locked fill went to the wrong segment");
    property p_preload;
        @(posedge clock) disable iff (!rst_n)
        startInstr |=> fillReq && fillIsInstr && preloadAddr[4:0] == 5'h00;
    endproperty
    a_preload: assert property (p_preload) else $error("preload did not start an instruction fill");
    property p_no_data_preload;
        @(posedge clock) disable iff (!rst_n)
        startData |=> !fillIsInstr;
    endproperty
    a_no_data_preload: assert property (p_no_data_preload) else $error("data fill marked as instruction");
    property p_single;
        @(posedge clock) disable iff (!rst_n)
        fillReq |=> !fillReq;
    endproperty
    a_single: assert property (p_single) else $error("fill request longer than one cycle");
    property p_ilock;
        @(posedge clock) disable iff (!rst_n)
        isLockWrite(copWrite, OP2_INSTR) |=> instrCtrl.loadMode == $past(copWrite.data[LOAD_BIT]);
    endproperty
    a_ilock: assert property (p_ilock) else $error("instruction load flag not stored");
endmodule
`default_nettype wire

// file: test_cache_segment_lockdown.sv
// Self-checking bench for the cache segment lockdown controller.
// Assumes lockdown_pkg and the controller are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module test_cache_segment_lockdown import lockdown_pkg::*; ;
    logic clock;
    logic rst_n;
    cop_write_t copWrite;
    logic copReadReq;
    logic [2:0] copReadOp2;
    logic dataMiss;
    logic fillWordDone;
    logic [31:0] copReadData;
    lock_ctrl_t dataCtrl;
    lock_ctrl_t instrCtrl;
    logic fillReq;
    logic fillIsInstr;
    logic [1:0] fillSegment;
    logic fillBusy;
    logic [31:0] preloadAddr;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int reqs = 0;

    cache_segment_lockdown uut (
        .clock(clock),
        .rst_n(rst_n),
        .copWrite(copWrite),
        .copReadReq(copReadReq),
        .copReadOp2(copReadOp2),
        .dataMiss(dataMiss),
        .fillWordDone(fillWordDone),
        .copReadData(copReadData),
        .dataCtrl(dataCtrl),
        .instrCtrl(instrCtrl),
        .fillReq(fillReq),
        .fillIsInstr(fillIsInstr),
        .fillSegment(fillSegment),
        .fillBusy(fillBusy),
        .preloadAddr(preloadAddr)
    );

    // Free-running core clock, 50 ns period
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard and fill request counter; a full run needs well under 600 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (fillReq === 1'b1)
            reqs++;
        if (cycles == 2000)
        begin
            fails++;
            $display("BAD %0t run did not finish", $time);
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Coprocessor write: valid stands for exactly one cycle
    task automatic cw(input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] d);
        @(posedge clock);
        copWrite <= {1'b1, crn, crm, op2, d};
        @(posedge clock);
        copWrite.valid <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] op2, input logic [31:0] exp);
        @(posedge clock);
        copReadReq <= 1'b1;
        copReadOp2 <= op2;
        @(posedge clock);
        copReadReq <= 1'b0;
        #1;
        chk(copReadData, exp);
    endtask

    // One line fill started by a miss or a preload; a stray miss mid-fill must be dropped
    task automatic fill(input logic instr, input logic [31:0] addr, input logic [1:0] seg);
        int n;
        int r0;
        r0 = reqs;
        @(posedge clock);
        if (instr)
            copWrite <= {1'b1, CREG_CACHEOP, CM_PRELOAD, OP2_INSTR, addr};
        else
            dataMiss <= 1'b1;
        @(posedge clock);
        copWrite.valid <= 1'b0;
        dataMiss <= 1'b0;
        #1;
        chk({31'h0, fillReq}, 32'h1);
        chk({31'h0, fillIsInstr}, {31'h0, instr});
        chk({30'h0, fillSegment}, {30'h0, seg});
        if (instr)
            chk(preloadAddr, addr & 32'hffff_ffe0);
        for (n = 0; n < 8; n++)
        begin
            @(posedge clock);
            fillWordDone <= 1'b1;
            dataMiss <= (n == 2);
            #1;
            if (n == 7)
                chk({31'h0, fillBusy}, 32'h1);
        end
        @(posedge clock);
        fillWordDone <= 1'b0;
        @(posedge clock);
        #1;
        chk({31'h0, fillBusy}, 32'h0);
        chk(reqs, r0 + 1);
    endtask

    initial
    begin
        rst_n = 1'b0;
        copWrite = '0;
        copReadReq = 1'b0;
        copReadOp2 = 3'h0;
        dataMiss = 1'b0;
        fillWordDone = 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rd(OP2_DATA, LOCKDOWN_RESET);
        rd(OP2_INSTR, LOCKDOWN_RESET);
        // Junk bits outside the flag and segment field must read back as zero
        cw(CREG_LOCKDOWN, 4'h0, OP2_DATA, 32'hffff_fffe);
        chk({29'h0, dataCtrl}, 32'h6);
        rd(OP2_DATA, 32'h8000_0002);
        chk({29'h0, instrCtrl}, 32'h0);
        $display("test registers done");
        // Lock segment 0 with two back-to-back lines, then segment 1
        cw(CREG_LOCKDOWN, 4'h0, OP2_DATA, 32'h8000_0000);
        fill(1'b0, 32'h0, 2'h0);
        fill(1'b0, 32'h20, 2'h0);
        chk({31'h0, fillBusy}, 32'h0);
        cw(CREG_LOCKDOWN, 4'h0, OP2_DATA, 32'h8000_0001);
        fill(1'b0, 32'h40, 2'h1);
        // Three segments locked: normal fills may only use segment 3
        cw(CREG_LOCKDOWN, 4'h0, OP2_DATA, 32'h0000_0003);
        fill(1'b0, 32'h60, 2'h3);
        fill(1'b0, 32'h80, 2'h3);
        $display("test data lockdown done");
        cw(CREG_LOCKDOWN, 4'h0, OP2_INSTR, 32'h8000_0001);
        chk({29'h0, instrCtrl}, 32'h5);
        rd(OP2_INSTR, 32'h8000_0001);
        fill(1'b1, 32'h0000_1234, 2'h1);
        $display("test instruction lockdown done");
        // Other registers leave lockdown alone; other cache operations start no fill
        cw(4'h5, 4'h0, OP2_DATA, 32'h8000_0000);
        rd(OP2_DATA, 32'h0000_0003);
        cw(CREG_CACHEOP, 4'he, OP2_INSTR, 32'h0000_0100);
        repeat (2) @(posedge clock);
        #1;
        chk({31'h0, fillBusy}, 32'h0);
        $display("test foreign writes done");
        test_done();
    end
endmodule
`default_nettype wire
